// ==== verilog/accessory_timing_pkg.sv ====
`default_nettype none

package accessory_timing_pkg;

    // ==========================================================
    // register index map, byte-wide registers
    localparam logic [7:0] IRQ_MASK_SECOND_ADDR = 8'h00;
    localparam logic [7:0] ID_CONVERSION_RESULT_ADDR = 8'h01;
    localparam logic [7:0] TIMING_POLL_AND_PRESS_ADDR = 8'h02;
    localparam logic [7:0] TIMING_HOLD_AND_SWITCH_ADDR = 8'h03;
    localparam logic [7:0] ACCESSORY_KIND_FIRST_ADDR = 8'h04;
    localparam logic [7:0] ACCESSORY_KIND_SECOND_ADDR = 8'h05;

    // ==========================================================
    // field widths, positions and reset values
    localparam int MASK_BITS = 5;
    localparam int RESULT_BITS = 5;
    localparam int CODE_BITS = 4;
    localparam int KIND_SECOND_BITS = 7;
    localparam int WAKE_LSB = 0;
    localparam int PRESS_LSB = 4;
    localparam int LONG_LSB = 0;
    localparam int SWITCH_LSB = 4;
    localparam int CONV_CHANGE_BIT = 2;
    localparam logic [4:0] MASK_RESET = 5'h00;
    localparam logic [4:0] RESULT_RESET = 5'h00;
    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [7:0] KIND_RESET = 8'h00;

    // ==========================================================
    // time base and code-to-duration tables, all in ms
    localparam int CLOCK_HZ = 125000000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;
    localparam int MS_BITS = 11;
    localparam int FIELD_WAKE = 0;
    localparam int FIELD_PRESS = 1;
    localparam int FIELD_LONG = 2;
    localparam int FIELD_SWITCH = 3;
    localparam int WAKE_FINE_STEP_MS = 50;
    localparam int WAKE_FINE_LAST = 3;
    localparam int WAKE_COARSE_STEP_MS = 100;
    localparam int WAKE_LAST = 11;
    localparam int WAKE_MAX_MS = 1000;
    localparam int PRESS_BASE_MS = 100;
    localparam int PRESS_STEP_MS = 100;
    localparam int PRESS_LAST = 9;
    localparam int PRESS_MAX_MS = 1000;
    localparam int LONG_BASE_MS = 300;
    localparam int LONG_STEP_MS = 100;
    localparam int LONG_LAST = 12;
    localparam int LONG_MAX_MS = 1500;
    localparam int SWITCH_BASE_MS = 10;
    localparam int SWITCH_STEP_MS = 20;
    localparam int SWITCH_LAST = 10;
    localparam int SWITCH_MAX_MS = 210;

    // ==========================================================
    // switch routes and sequencing
    localparam logic [1:0] ROUTE_OPEN = 2'h0;
    localparam logic [1:0] ROUTE_USB = 2'h1;
    localparam logic [1:0] ROUTE_AUDIO = 2'h2;
    localparam logic [1:0] ROUTE_UART = 2'h3;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_DELAY = 2'b01,
        SW_CLOSED = 2'b11,
        SW_HOLD = 2'b10
    } switch_state_type;

endpackage

`default_nettype wire

// ==== verilog/duration_decode.sv ====
`default_nettype none

module duration_decode
    import accessory_timing_pkg::*;
#(
    parameter int FIELD = FIELD_WAKE
) (
    // code in
    input wire logic [CODE_BITS-1:0] code_i,
    // duration out
    output logic [MS_BITS-1:0] ms_o
);

    // ==========================================================
    // undefined codes saturate at the longest time of the field
    always_comb begin
        int c;
        int ms;
        c = int'(code_i);
        ms = 0;
        case (FIELD)
            FIELD_WAKE: begin
                if (c <= WAKE_FINE_LAST) begin
                    ms = WAKE_FINE_STEP_MS * (c + 1); // [R05]
                end else if (c <= WAKE_LAST) begin
                    ms = WAKE_COARSE_STEP_MS * (c - 1); // [R05]
                end else begin
                    ms = WAKE_MAX_MS; // [R19]
                end
            end
            FIELD_PRESS: begin
                ms = (c <= PRESS_LAST) ? PRESS_BASE_MS + PRESS_STEP_MS * c : PRESS_MAX_MS; // [R06]
            end
            FIELD_LONG: begin
                ms = (c <= LONG_LAST) ? LONG_BASE_MS + LONG_STEP_MS * c : LONG_MAX_MS; // [R07]
            end
            default: begin
                ms = (c <= SWITCH_LAST) ? SWITCH_BASE_MS + SWITCH_STEP_MS * c : SWITCH_MAX_MS; // [R08]
            end
        endcase
        ms_o = MS_BITS'(ms);
    end

endmodule

`default_nettype wire

// ==== verilog/ms_counter.sv ====
`default_nettype none

module ms_counter
    import accessory_timing_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // control
    input wire logic clear_i,
    input wire logic tick_i,
    // elapsed milliseconds
    output logic [MS_BITS-1:0] count_o
);

    logic [MS_BITS-1:0] next_count;

    // ==========================================================
    // saturates so a held key never wraps; the tick phase is free, so the key and switch users compare with >, the wake-up user with >=
    always_comb begin
        next_count = count_o;
        if (clear_i) begin
            next_count = '0;
        end else if (tick_i && (count_o != {MS_BITS{1'b1}})) begin
            next_count = count_o + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_o <= '0;
        end else begin
            count_o <= next_count;
        end
    end

endmodule

`default_nettype wire

// ==== verilog/accessory_detect_timing_regs.sv ====
`default_nettype none

// Notes on behaviour
// R01: five mask bits block events, reset zero
// R02: five-bit ID conversion result, upper bits zero
// R03: wake-up field paces ID sampling in standby
// R04: wake-up field paces conversions when periodic reporting
// R05: wake-up code decode, 50 to 1000 ms
// R06: key press code 100 to 1000 ms
// R07: long key press code 300 to 1500 ms
// R08: switch delay code 10 to 210 ms
// R09: type one bits zero to three flags
// R10: type one bits four to six chargers
// R11: type one bit seven on-the-go device
// R12: type two bits zero to three jigs
// R13: type two bits four to six, seven zero
// R14: wait bit set closes switches after delay
// R15: report bit picks conversions or key monitor
// R16: automatic mode routes switches from type registers
// R17: mask bits follow second interrupt event order
// R18: reserved bits read zero, writes ignored
// R19: host writes defined codes; undefined saturate longest
module accessory_detect_timing_regs
    import accessory_timing_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // register port from the serial interface
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // control bits held elsewhere
    input wire logic wait_ctrl_i,
    input wire logic auto_switch_i,
    input wire logic report_sel_i,
    input wire logic low_power_i,
    input wire logic [1:0] manual_route_i,
    // detector and converter
    input wire logic [7:0] kind_first_i,
    input wire logic [KIND_SECOND_BITS-1:0] kind_second_i,
    input wire logic attached_i,
    input wire logic [RESULT_BITS-1:0] adc_code_i,
    input wire logic adc_valid_i,
    input wire logic key_down_i,
    // second group of interrupt events
    input wire logic [MASK_BITS-1:0] event_second_i,
    output logic [MASK_BITS-1:0] event_second_gated_o,
    // timing outputs
    output logic id_sample_o,
    output logic conv_start_o,
    output logic key_press_o,
    output logic long_press_o,
    output logic long_release_o,
    // switches
    output logic switch_on_o,
    output logic [1:0] switch_route_o
);

    // ==========================================================
    // register state
    logic [MASK_BITS-1:0] irq_mask_second, next_irq_mask_second;
    logic [RESULT_BITS-1:0] id_conversion_result, next_id_conversion_result;
    logic [7:0] timing_poll_and_press, next_timing_poll_and_press;
    logic [7:0] timing_hold_and_switch, next_timing_hold_and_switch;
    logic [7:0] accessory_kind_first, next_accessory_kind_first;
    logic [KIND_SECOND_BITS-1:0] accessory_kind_second, next_accessory_kind_second;
    logic [7:0] next_reg_rdata;
    logic conv_change, next_conv_change;
    logic [MASK_BITS-1:0] next_event_gated;

    always_comb begin
        next_irq_mask_second = irq_mask_second;
        next_timing_poll_and_press = timing_poll_and_press;
        next_timing_hold_and_switch = timing_hold_and_switch;
        if (reg_wr_i) begin
            case (reg_addr_i)
                IRQ_MASK_SECOND_ADDR: next_irq_mask_second = reg_wdata_i[MASK_BITS-1:0]; // [R18]
                TIMING_POLL_AND_PRESS_ADDR: next_timing_poll_and_press = reg_wdata_i;
                TIMING_HOLD_AND_SWITCH_ADDR: next_timing_hold_and_switch = reg_wdata_i;
                default: next_irq_mask_second = irq_mask_second;
            endcase
        end
        // the type registers mirror the detector, and read data is registered again, so a read can be up to two cycles stale
        next_accessory_kind_first = kind_first_i; // [R09] [R10] [R11]
        next_accessory_kind_second = kind_second_i; // [R12] [R13]
        // result only moves on a finished conversion; a change is reported in periodic mode
        next_id_conversion_result = id_conversion_result;
        next_conv_change = 1'b0;
        if (adc_valid_i) begin
            next_id_conversion_result = adc_code_i; // [R02]
            next_conv_change = !report_sel_i && (adc_code_i != id_conversion_result); // [R15]
        end
        // bit order of the mask matches the second event group
        next_event_gated = event_second_i & ~irq_mask_second; // [R01] [R17]
        next_event_gated[CONV_CHANGE_BIT] = (event_second_i[CONV_CHANGE_BIT] | conv_change)
            & ~irq_mask_second[CONV_CHANGE_BIT]; // [R17]
        case (reg_addr_i)
            IRQ_MASK_SECOND_ADDR: next_reg_rdata = {3'h0, irq_mask_second}; // [R18]
            ID_CONVERSION_RESULT_ADDR: next_reg_rdata = {3'h0, id_conversion_result}; // [R02]
            TIMING_POLL_AND_PRESS_ADDR: next_reg_rdata = timing_poll_and_press;
            TIMING_HOLD_AND_SWITCH_ADDR: next_reg_rdata = timing_hold_and_switch;
            ACCESSORY_KIND_FIRST_ADDR: next_reg_rdata = accessory_kind_first;
            ACCESSORY_KIND_SECOND_ADDR: next_reg_rdata = {1'b0, accessory_kind_second}; // [R13]
            default: next_reg_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_mask_second <= MASK_RESET; // [R01]
            id_conversion_result <= RESULT_RESET;
            timing_poll_and_press <= TIMING_RESET;
            timing_hold_and_switch <= TIMING_RESET;
            accessory_kind_first <= KIND_RESET;
            accessory_kind_second <= KIND_SECOND_BITS'(KIND_RESET);
            reg_rdata_o <= 8'h00;
            conv_change <= 1'b0;
            event_second_gated_o <= '0;
        end else begin
            irq_mask_second <= next_irq_mask_second;
            id_conversion_result <= next_id_conversion_result;
            timing_poll_and_press <= next_timing_poll_and_press;
            timing_hold_and_switch <= next_timing_hold_and_switch;
            accessory_kind_first <= next_accessory_kind_first;
            accessory_kind_second <= next_accessory_kind_second;
            reg_rdata_o <= next_reg_rdata;
            conv_change <= next_conv_change;
            event_second_gated_o <= next_event_gated;
        end
    end

    // ==========================================================
    // durations and millisecond time base
    logic [MS_BITS-1:0] wake_ms, press_ms, long_ms, switch_ms;
    logic [16:0] prescale, next_prescale;
    logic ms_tick, next_ms_tick;

    duration_decode #(.FIELD(FIELD_WAKE)) wake_decode (
        .code_i(timing_poll_and_press[WAKE_LSB +: CODE_BITS]),
        .ms_o(wake_ms)
    );
    duration_decode #(.FIELD(FIELD_PRESS)) press_decode (
        .code_i(timing_poll_and_press[PRESS_LSB +: CODE_BITS]),
        .ms_o(press_ms)
    );
    duration_decode #(.FIELD(FIELD_LONG)) long_decode (
        .code_i(timing_hold_and_switch[LONG_LSB +: CODE_BITS]),
        .ms_o(long_ms)
    );
    duration_decode #(.FIELD(FIELD_SWITCH)) switch_decode (
        .code_i(timing_hold_and_switch[SWITCH_LSB +: CODE_BITS]),
        .ms_o(switch_ms)
    );

    always_comb begin
        next_ms_tick = (prescale == 17'(MS_CYCLES - 1));
        next_prescale = next_ms_tick ? 17'h0 : prescale + 17'h1;
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prescale <= 17'h0;
            ms_tick <= 1'b0;
        end else begin
            prescale <= next_prescale;
            ms_tick <= next_ms_tick;
        end
    end

    // ==========================================================
    // periodic wake-up: ID sampling and conversion starts
    logic [MS_BITS-1:0] wake_count;
    logic wake_active, wake_due;

    assign wake_active = low_power_i || !report_sel_i; // [R03] [R04]
    assign wake_due = wake_active && (wake_count >= wake_ms);

    ms_counter wake_counter (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .clear_i(wake_due || !wake_active),
        .tick_i(ms_tick),
        .count_o(wake_count)
    );

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            id_sample_o <= 1'b0;
            conv_start_o <= 1'b0;
        end else begin
            id_sample_o <= wake_due && low_power_i; // [R03]
            conv_start_o <= wake_due && !report_sel_i; // [R04]
        end
    end

    // ==========================================================
    // key monitor, only while the report bit selects it
    logic key_meta, key_sync;
    logic [MS_BITS-1:0] key_count;
    logic key_fired, next_key_fired, long_fired, next_long_fired;
    logic next_key_press, next_long_press, next_long_release;
    logic key_held;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            key_meta <= 1'b0;
            key_sync <= 1'b0;
        end else begin
            key_meta <= key_down_i;
            key_sync <= key_meta;
        end
    end

    assign key_held = key_sync && report_sel_i; // [R15]

    ms_counter key_counter (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .clear_i(!key_held),
        .tick_i(ms_tick),
        .count_o(key_count)
    );

    always_comb begin
        next_key_fired = key_fired;
        next_long_fired = long_fired;
        next_key_press = 1'b0;
        next_long_press = 1'b0;
        next_long_release = 1'b0;
        if (!key_held) begin
            next_long_release = long_fired;
            next_key_fired = 1'b0;
            next_long_fired = 1'b0;
        end else begin
            if (!key_fired && key_count > press_ms) begin
                next_key_press = 1'b1; // [R06]
                next_key_fired = 1'b1;
            end
            if (!long_fired && key_count > long_ms) begin
                next_long_press = 1'b1; // [R07]
                next_long_fired = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            key_fired <= 1'b0;
            long_fired <= 1'b0;
            key_press_o <= 1'b0;
            long_press_o <= 1'b0;
            long_release_o <= 1'b0;
        end else begin
            key_fired <= next_key_fired;
            long_fired <= next_long_fired;
            key_press_o <= next_key_press;
            long_press_o <= next_long_press;
            long_release_o <= next_long_release;
        end
    end

    // ==========================================================
    // switch sequencing and routing
    switch_state_type sw_state, next_sw_state;
    logic [MS_BITS-1:0] switch_count;
    logic [1:0] auto_route, next_route;

    ms_counter switch_counter (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .clear_i(sw_state != SW_DELAY),
        .tick_i(ms_tick),
        .count_o(switch_count)
    );

    always_comb begin
        next_sw_state = sw_state;
        case (sw_state)
            SW_IDLE: begin
                if (attached_i) begin
                    next_sw_state = wait_ctrl_i ? SW_DELAY : SW_HOLD;
                end
            end
            SW_DELAY: begin
                if (!attached_i) begin
                    next_sw_state = SW_IDLE;
                end else if (switch_count > switch_ms) begin
                    next_sw_state = SW_CLOSED; // [R14]
                end
            end
            SW_HOLD: begin
                // cleared wait bit holds until software sets it, then closes at once
                if (!attached_i) begin
                    next_sw_state = SW_IDLE;
                end else if (wait_ctrl_i) begin
                    next_sw_state = SW_CLOSED;
                end
            end
            SW_CLOSED: begin
                if (!attached_i) begin
                    next_sw_state = SW_IDLE;
                end
            end
            default: next_sw_state = SW_IDLE;
        endcase
        // usb first: a charger on a usb host still needs the data path
        if (accessory_kind_first[2] || (|accessory_kind_second[1:0])) begin
            auto_route = ROUTE_USB;
        end else if (accessory_kind_first[3] || (|accessory_kind_second[3:2])) begin
            auto_route = ROUTE_UART;
        end else if (|accessory_kind_first[1:0]) begin
            auto_route = ROUTE_AUDIO;
        end else begin
            auto_route = ROUTE_OPEN;
        end
        next_route = auto_switch_i ? auto_route : manual_route_i; // [R16]
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sw_state <= SW_IDLE;
            switch_on_o <= 1'b0;
            switch_route_o <= ROUTE_OPEN;
        end else begin
            sw_state <= next_sw_state;
            switch_on_o <= (next_sw_state == SW_CLOSED);
            switch_route_o <= next_route;
        end
    end

    // ==========================================================
    // checks
    mask_gate_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [R01]
        ##1 ((event_second_gated_o & $past(irq_mask_second)) == '0))
        else $error("masked event reached the output");
    result_upper_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [R02]
        $past(reg_addr_i) == ID_CONVERSION_RESULT_ADDR |-> reg_rdata_o[7:5] == 3'h0)
        else $error("result upper bits not zero");
    wake_bound_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [R05]
        wake_ms >= MS_BITS'(WAKE_FINE_STEP_MS) && wake_ms <= MS_BITS'(WAKE_MAX_MS))
        else $error("wake period out of range");
    conv_pulse_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [R04]
        conv_start_o |-> $past(!report_sel_i) ##1 !conv_start_o)
        else $error("conversion start wrong");
    long_after_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [R07]
        long_press_o |-> $past(key_count) > $past(long_ms) && $past(report_sel_i))
        else $error("long press too early");
    switch_delay_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [R14]
        $rose(switch_on_o) && $past(sw_state) == SW_DELAY
        |-> $past(switch_count) > $past(switch_ms))
        else $error("switches closed before delay");
    kind_top_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [R13]
        $past(reg_addr_i) == ACCESSORY_KIND_SECOND_ADDR |-> !reg_rdata_o[7])
        else $error("reserved type bit set");
    mask_reserved_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [R18]
        $past(reg_addr_i) == IRQ_MASK_SECOND_ADDR |-> reg_rdata_o[7:5] == 3'h0)
        else $error("reserved mask bits set");
    auto_route_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [R16]
        $past(auto_switch_i) && $past(accessory_kind_first[2]) |-> switch_route_o == ROUTE_USB)
        else $error("auto route wrong");

endmodule

`default_nettype wire

// ==== bench/host_model.sv ====
`default_nettype none
// ==========
// host side of the register port
module host_model (
    // clock
    input wire logic clock_i,
    // register port
    input wire logic [7:0] reg_rdata_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // one-cycle strobe; callers pass defined codes only
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_o <= a;
        reg_wr_o <= 1'b1;
        reg_wdata_o <= d;
        @(posedge clock_i);
        reg_wr_o <= 1'b0;
    endtask
    // data is registered, so wait one edge past the sample edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_o <= a;
        @(posedge clock_i);
        @(posedge clock_i);
        d = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// ==== bench/test_accessory_detect_timing_regs.sv ====
`default_nettype none
module test_accessory_detect_timing_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr, wdata, rdata, kind1, rd;
    logic wr, waitc = 1'b0, attached = 1'b0, key = 1'b0, valid = 1'b0;
    logic [6:0] kind2 = 7'h00;
    logic [4:0] adc = 5'h00, ev = 5'h00, gated;
    logic swon, kp;
    logic autosw = 1'b0, rsel = 1'b1, lowp = 1'b0, idsmp, cstart, lp, lr;
    logic [1:0] mroute = 2'h1, route;
    int mismatches = 0;
    int total_checks = 0;
    int n;
    always #4 clock_i = ~clock_i;
    initial kind1 = 8'h00;
    host_model i_host_model (.clock_i(clock_i), .reg_rdata_i(rdata),
        .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata));
    accessory_detect_timing_regs #(.MS_CYCLES(10)) i_accessory_detect_timing_regs (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .wait_ctrl_i(waitc),
        .auto_switch_i(autosw), .report_sel_i(rsel), .low_power_i(lowp),
        .manual_route_i(mroute), .kind_first_i(kind1), .kind_second_i(kind2),
        .attached_i(attached), .adc_code_i(adc), .adc_valid_i(valid),
        .key_down_i(key), .event_second_i(ev), .event_second_gated_o(gated),
        .id_sample_o(idsmp), .conv_start_o(cstart), .key_press_o(kp), .long_press_o(lp),
        .long_release_o(lr), .switch_on_o(swon), .switch_route_o(route));
    // ==========
    // compare and close
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("CHECK FAILED t=%0t cycles %0d", $time, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_reset;
        for (int a = 0; a < 7; a++) begin
            i_host_model.read_reg(a[7:0], rd);
            check8(rd, 8'h00);
        end
    endtask
    task automatic t_mask;
        ev <= 5'h1F;
        i_host_model.write_reg(8'h00, 8'hFF);
        i_host_model.read_reg(8'h00, rd);
        check8(rd, 8'h1F);
        check8({3'h0, gated}, 8'h00);
        i_host_model.write_reg(8'h00, 8'h0A);
        i_host_model.read_reg(8'h00, rd);
        check8({3'h0, gated}, 8'h15);
        ev <= 5'h00;
    endtask
    task automatic t_regs;
        kind1 <= 8'hA5;
        kind2 <= 7'h7F;
        i_host_model.write_reg(8'h02, 8'h9B);
        i_host_model.read_reg(8'h02, rd);
        check8(rd, 8'h9B);
        i_host_model.write_reg(8'h03, 8'hAC);
        i_host_model.read_reg(8'h03, rd);
        check8(rd, 8'hAC);
        i_host_model.write_reg(8'h04, 8'h5A);
        i_host_model.read_reg(8'h04, rd);
        check8(rd, 8'hA5);
        i_host_model.read_reg(8'h05, rd);
        check8(rd, 8'h7F);
    endtask
    task automatic t_adc;
        @(posedge clock_i);
        adc <= 5'h13;
        valid <= 1'b1;
        @(posedge clock_i);
        valid <= 1'b0;
        i_host_model.read_reg(8'h01, rd);
        check8(rd, 8'h13);
    endtask
    task automatic t_route;
        @(posedge clock_i);
        mroute <= 2'h2;
        repeat (3) @(posedge clock_i);
        check8({6'h00, route}, 8'h02);
        autosw <= 1'b1;
        repeat (3) @(posedge clock_i);
        check8({6'h00, route}, 8'h01);
        kind1 <= 8'h08;
        kind2 <= 7'h00;
        repeat (3) @(posedge clock_i);
        check8({6'h00, route}, 8'h03);
        autosw <= 1'b0;
    endtask
    task automatic t_conv;
        @(posedge clock_i);
        rsel <= 1'b0;
        lowp <= 1'b1;
        adc <= 5'h07;
        valid <= 1'b1;
        @(posedge clock_i);
        valid <= 1'b0;
        repeat (2) @(posedge clock_i);
        check8({3'h0, gated}, 8'h04);
        n = 0;
        while (cstart !== 1'b1 && n < 700) begin
            @(posedge clock_i);
            n++;
        end
        @(posedge clock_i);
        n = 1;
        while (cstart !== 1'b1 && n < 700) begin
            @(posedge clock_i);
            n++;
        end
        check_rng(n, 500, 500);
        check8({7'h00, idsmp}, 8'h01);
        rsel <= 1'b1;
        lowp <= 1'b0;
    endtask
    task automatic t_switch;
        // code 0 on both fields: 10 ms switch delay, 100 ms press
        i_host_model.write_reg(8'h03, 8'h00);
        i_host_model.write_reg(8'h02, 8'h00);
        @(posedge clock_i);
        waitc <= 1'b1;
        attached <= 1'b1;
        n = 0;
        while (swon !== 1'b1 && n < 400) begin
            @(posedge clock_i);
            n++;
        end
        check_rng(n, 95, 115);
        attached <= 1'b0;
        repeat (3) @(posedge clock_i);
        check8({7'h00, swon}, 8'h00);
    endtask
    task automatic t_key;
        @(posedge clock_i);
        key <= 1'b1;
        n = 0;
        while (kp !== 1'b1 && n < 2000) begin
            @(posedge clock_i);
            n++;
        end
        check_rng(n, 995, 1020);
        while (lp !== 1'b1 && n < 4000) begin
            @(posedge clock_i);
            n++;
        end
        check_rng(n, 2995, 3020);
        key <= 1'b0;
        repeat (4) @(posedge clock_i);
        check8({7'h00, lr}, 8'h01);
    endtask
    // ==========
    // main sequence and watchdog
    initial begin
        repeat (10) @(posedge clock_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_mask();
        t_regs();
        t_adc();
        t_route();
        t_switch();
        t_conv();
        t_key();
        close_out();
    end
    initial begin
        // all scenarios need a few thousand cycles
        #200000;
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
